// ==== isb_defines.svh ====
// Register offsets, field positions and reset values of the enable bank.
`ifndef ISB_DEFINES_SVH
`define ISB_DEFINES_SVH

`define ISB_ADDR_EN_MISC 8'h7d
`define ISB_ADDR_EN_DRV 8'h7e
`define ISB_ADDR_CHIP_ID 8'hff
`define ISB_MISC_DRV9_BIT 7
`define ISB_MISC_BADCFG_BIT 2
`define ISB_ENABLE_RESET 8'h00
`define ISB_READ_IDLE 8'h00
`define ISB_CHIP_ID_DEFAULT 8'h5a // Arbitrary value, names no real part.
`define ISB_MISC_MASK 8'h84

`endif

// ==== isb_pkg.sv ====
// Types shared by the interrupt-two source enable bank.
package isb_pkg;

  typedef logic [7:0] isb_addr_t;
  typedef logic [7:0] isb_byte_t;

  typedef struct packed {
    isb_byte_t drvEnable;
    logic drv9Enable;
    logic badConfigEnable;
    logic irqTwo;
    isb_byte_t rdData;
  } isb_state_s;

endpackage : isb_pkg

// ==== isb_enable_bank.sv ====
// Interrupt-two source enables for the driver comparators and bad config.
`timescale 1ns/1ps
`default_nettype none
`include "isb_defines.svh"

module isb_enable_bank #(
  parameter int NUM_BANK_DRV = 8,
  parameter logic [7:0] CHIP_ID = `ISB_CHIP_ID_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire isb_pkg::isb_addr_t regAddr,
  input wire isb_pkg::isb_byte_t regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic [NUM_BANK_DRV:0] drvComparatorFlag,
  input wire logic badConfigFlag,
  output logic interruptOutTwo
);
  import isb_pkg::*;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // The identifier value above is arbitrary and names no real part.

  isb_state_s stateQ;
  isb_state_s stateD;
  logic [NUM_BANK_DRV-1:0] drvHit;
  logic anyHit;
  logic wrDrv;
  logic wrMisc;

  assign wrDrv = regWrEn && (regAddr == `ISB_ADDR_EN_DRV);
  assign wrMisc = regWrEn && (regAddr == `ISB_ADDR_EN_MISC);

  // Each bank bit gates the comparator flag of the driver with the same
  // index, so bit i gates flag i.
  for (genvar i = 0; i < NUM_BANK_DRV; i++) begin : g_drv
    assign drvHit[i] = stateQ.drvEnable[i] & drvComparatorFlag[i];

    a_drv_bit_gate: assert property (
      @(posedge sys_clk) disable iff (rst)
      (stateQ.drvEnable[i] && drvComparatorFlag[i]) |=> interruptOutTwo)
      else $error("Enabled driver comparator flag did not raise irq two.");
  end

  // Every gated source is ORed here and the result is registered, so the
  // pin never shows a decode glitch.
  always_comb begin
    anyHit = |drvHit;
    anyHit = anyHit
      | (stateQ.drv9Enable & drvComparatorFlag[NUM_BANK_DRV])
      | (stateQ.badConfigEnable & badConfigFlag);
  end

  always_comb begin
    stateD = stateQ;
    stateD.irqTwo = anyHit;
    if (wrDrv) begin
      stateD.drvEnable = regWrData;
    end
    if (wrMisc) begin
      stateD.drv9Enable = regWrData[`ISB_MISC_DRV9_BIT];
      stateD.badConfigEnable = regWrData[`ISB_MISC_BADCFG_BIT];
    end
    // A write to the identifier address matches neither decode above.
    // Read data is registered so that it stands until the next read
    // and reaches the port straight from a flip-flop.
    if (regRdEn) begin
      unique case (regAddr)
        `ISB_ADDR_EN_DRV: begin
          stateD.rdData = stateQ.drvEnable;
        end
        `ISB_ADDR_EN_MISC: begin
          stateD.rdData = `ISB_READ_IDLE;
          stateD.rdData[`ISB_MISC_DRV9_BIT] = stateQ.drv9Enable;
          stateD.rdData[`ISB_MISC_BADCFG_BIT] = stateQ.badConfigEnable;
        end
        `ISB_ADDR_CHIP_ID: begin
          stateD.rdData = CHIP_ID;
        end
        default: begin
          stateD.rdData = `ISB_READ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stateQ <= '{drvEnable: `ISB_ENABLE_RESET, drv9Enable: 1'b0,
                  badConfigEnable: 1'b0, irqTwo: 1'b0,
                  rdData: `ISB_READ_IDLE};
    end else begin
      stateQ <= stateD;
    end
  end

  // The interrupt is the registered OR, one clock behind its sources.
  assign interruptOutTwo = stateQ.irqTwo;
  assign regRdData = stateQ.rdData;

  // Each step of a register transfer is written as its own sequence.
  sequence s_write_drv_bank;
    regWrEn && !regRdEn && regAddr == `ISB_ADDR_EN_DRV;
  endsequence

  sequence s_read_drv_bank;
    regRdEn && !regWrEn && regAddr == `ISB_ADDR_EN_DRV;
  endsequence

  a_bad_cfg_gate: assert property (
    (stateQ.badConfigEnable && badConfigFlag) |=> interruptOutTwo)
    else $error("Enabled bad-config flag did not raise irq two.");

  a_drv9_gate: assert property (
    (stateQ.drv9Enable && drvComparatorFlag[NUM_BANK_DRV])
      |=> interruptOutTwo)
    else $error("Enabled driver-nine flag did not raise irq two.");

  a_irq_or_follow: assert property (
    ##1 interruptOutTwo == $past(anyHit))
    else $error("Irq two does not follow the OR of enabled sources.");

  a_irq_quiet_masked: assert property (
    (stateQ.drvEnable == `ISB_ENABLE_RESET && !stateQ.drv9Enable
      && !stateQ.badConfigEnable && !wrDrv && !wrMisc)
      |=> ##1 !interruptOutTwo)
    else $error("Irq two rose with every source disabled.");

  a_id_read_value: assert property (
    (regRdEn && regAddr == `ISB_ADDR_CHIP_ID) |=> regRdData == CHIP_ID)
    else $error("Identifier read returned a wrong value.");

  a_id_write_ignored: assert property (
    (regWrEn && regAddr == `ISB_ADDR_CHIP_ID)
      |=> $stable(stateQ.drvEnable) && $stable(stateQ.drv9Enable)
        && $stable(stateQ.badConfigEnable))
    else $error("Write to the identifier changed an enable.");

  a_bank_readback: assert property (
    (s_write_drv_bank ##1 s_read_drv_bank)
      |=> regRdData == $past(regWrData, 2))
    else $error("Driver enable bank did not read back the written byte.");

  sequence s_write_misc;
    regWrEn && !regRdEn && regAddr == `ISB_ADDR_EN_MISC;
  endsequence

  sequence s_read_misc;
    regRdEn && !regWrEn && regAddr == `ISB_ADDR_EN_MISC;
  endsequence

  // With no source both enabled and flagged, interrupt two must stay low.
  a_irq_low_unarmed: assert property (
    ((stateQ.drvEnable & drvComparatorFlag[NUM_BANK_DRV-1:0]) == '0
      && !(stateQ.drv9Enable && drvComparatorFlag[NUM_BANK_DRV])
      && !(stateQ.badConfigEnable && badConfigFlag))
      |=> !interruptOutTwo)
    else $error("Irq two rose without an enabled flagged source.");

  a_bad_cfg_masked: assert property (
    (!stateQ.badConfigEnable && badConfigFlag && !stateQ.drv9Enable
      && stateQ.drvEnable == `ISB_ENABLE_RESET) |=> !interruptOutTwo)
    else $error("Disabled bad-config flag raised irq two.");

  a_drv9_masked: assert property (
    (!stateQ.drv9Enable && drvComparatorFlag[NUM_BANK_DRV]
      && !stateQ.badConfigEnable && stateQ.drvEnable == `ISB_ENABLE_RESET)
      |=> !interruptOutTwo)
    else $error("Disabled driver-nine flag raised irq two.");

  a_drv_bank_write: assert property (
    s_write_drv_bank |=> stateQ.drvEnable == $past(regWrData))
    else $error("Driver enable bank did not take the written byte.");

  a_misc_readback: assert property (
    (s_write_misc ##1 s_read_misc)
      |=> regRdData == ($past(regWrData, 2) & `ISB_MISC_MASK))
    else $error("Misc enables did not read back the written bits.");

  a_misc_reserved_zero: assert property (
    (regRdEn && regAddr == `ISB_ADDR_EN_MISC)
      |=> (regRdData & ~`ISB_MISC_MASK) == `ISB_READ_IDLE)
    else $error("Reserved misc enable bits did not read as zero.");

  // A read that meets a write in the same cycle returns the old enables.
  a_rdwr_old_value: assert property (
    (regRdEn && regWrEn && regAddr == `ISB_ADDR_EN_DRV)
      |=> regRdData == $past(stateQ.drvEnable))
    else $error("Coinciding read did not return the old enable bank.");

  a_unmapped_read_zero: assert property (
    (regRdEn && regAddr != `ISB_ADDR_EN_DRV
      && regAddr != `ISB_ADDR_EN_MISC && regAddr != `ISB_ADDR_CHIP_ID)
      |=> regRdData == `ISB_READ_IDLE)
    else $error("Unmapped read did not return zero.");

  a_unmapped_write_ignored: assert property (
    (regWrEn && regAddr != `ISB_ADDR_EN_DRV
      && regAddr != `ISB_ADDR_EN_MISC)
      |=> $stable(stateQ.drvEnable) && $stable(stateQ.drv9Enable)
        && $stable(stateQ.badConfigEnable))
    else $error("Write to an unmapped address changed an enable.");

  // Read data stands until the next read strobe.
  a_rd_data_hold: assert property (
    !regRdEn |=> $stable(regRdData))
    else $error("Read data changed without a read strobe.");

endmodule : isb_enable_bank
`default_nettype wire

// ==== isb_enable_bank_tb.sv ====
// Self-checking bench for the interrupt-two source enable bank.
`timescale 1ns/1ps
`default_nettype none
module isb_enable_bank_tb;
  import isb_pkg::*;
  localparam logic [7:0] ID = 8'h3c; // Arbitrary identifier value.
  logic sys_clk, rst, regWrEn, regRdEn, badConfigFlag, interruptOutTwo;
  isb_addr_t regAddr;
  isb_byte_t regWrData;
  logic [7:0] regRdData;
  logic [8:0] drvComparatorFlag;
  int failures, compares, en7e, en7d;
  isb_enable_bank #(.NUM_BANK_DRV(8), .CHIP_ID(ID)) i_isb_enable_bank (
    .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .drvComparatorFlag(drvComparatorFlag),
    .badConfigFlag(badConfigFlag), .interruptOutTwo(interruptOutTwo));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h7e) en7e = d;
    if (a == 8'h7d) en7d = d & 8'h84;
    @(posedge sys_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic [7:0] e;
    e = (a == 8'h7e) ? en7e[7:0] : (a == 8'h7d) ? en7d[7:0] :
        (a == 8'hff) ? ID : 8'h00;
    @(posedge sys_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    @(negedge sys_clk);
    chk(regRdData, e);
  endtask : rd
  // Write then read one address, in the same cycle or back to back.
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                       input logic same);
    logic [7:0] e;
    e = (a == 8'h7e) ? en7e[7:0] : en7d[7:0];
    @(posedge sys_clk);
    regWrEn <= 1'b1;
    regRdEn <= same;
    regAddr <= a;
    regWrData <= d;
    if (a == 8'h7e) en7e = d;
    if (a == 8'h7d) en7d = d & 8'h84;
    if (!same) e = (a == 8'h7e) ? en7e[7:0] : en7d[7:0];
    @(posedge sys_clk);
    regWrEn <= 1'b0;
    if (same) begin
      regRdEn <= 1'b0;
    end else begin
      regRdEn <= 1'b1;
      @(posedge sys_clk);
      regRdEn <= 1'b0;
    end
    @(negedge sys_clk);
    chk(regRdData, e);
  endtask : wr_rd
  // The output lags the sampled flags and enables by one clock.
  task automatic irq(input logic [8:0] f, input logic b);
    logic e;
    e = |(en7e[7:0] & f[7:0]) | (en7d[7] & f[8]) | (en7d[2] & b);
    @(posedge sys_clk);
    drvComparatorFlag <= f;
    badConfigFlag <= b;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk({7'h00, interruptOutTwo}, {7'h00, e});
  endtask : irq
  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    logic [9:0] s;
    {failures, compares, en7e, en7d} = '0;
    {rst, regWrEn, regRdEn, badConfigFlag} = 4'h8;
    {regAddr, regWrData, drvComparatorFlag} = '0;
    void'($urandom(84));
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rd(8'h7e);
    rd(8'h7d);
    wr(8'hff, 8'hff);
    wr(8'h10, 8'hff);
    rd(8'h7e);
    rd(8'h7d);
    rd(8'hff);
    rd(8'h10);
    wr_rd(8'h7e, 8'ha5, 1'b0);
    wr_rd(8'h7e, 8'h3c, 1'b1);
    rd(8'h7e);
    wr_rd(8'h7d, 8'hff, 1'b0);
    wr_rd(8'h7d, 8'h00, 1'b1);
    rd(8'h7d);
    for (int i = 0; i < 10; i++) begin
      s = 10'h001 << i;
      wr(8'h7e, s[7:0]);
      wr(8'h7d, {s[8], 4'h0, s[9], 2'h0});
      irq(s[8:0], s[9]);
      irq(~s[8:0], ~s[9]);
    end
    for (int i = 0; i < 40; i++) begin
      wr(8'h7e, 8'($urandom));
      wr(8'h7d, 8'($urandom));
      rd(8'h7e);
      rd(8'h7d);
      irq(9'($urandom), 1'($urandom));
      wr_rd(8'h7e, 8'($urandom), 1'($urandom));
    end
    wr(8'h7e, 8'hff);
    rd(8'h7e);
    irq(9'h1ff, 1'b1);
    @(posedge sys_clk);
    rst <= 1'b1;
    en7e = 0;
    en7d = 0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk(regRdData, 8'h00);
    chk({7'h00, interruptOutTwo}, 8'h00);
    irq(9'h1ff, 1'b1);
    rd(8'h7e);
    rd(8'h7d);
    tally_and_finish();
  end
endmodule : isb_enable_bank_tb
`default_nettype wire
